// file: rtl/adc_seq_pkg.sv
// Shared constants and types for the converter exchange sequencer.
// Assumes a single 200 MHz system clock; pin clocks are sampled, not used as clocks.
package adc_seq_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Exchange and conversion timing, in link or conversion clock counts
    localparam int EXCH_CYCLES = 10;
    localparam int CONV_CYCLES = 41;
    localparam int ADDR_BITS = 4;
    localparam int SAMPLE_HALF_PERIODS = 9;
    localparam int LEAD_ZEROS = 6;
    localparam int RESULT_BITS = 10;
    localparam int SHIFT_BITS = 16;
    localparam int CHAN_BITS = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin indices into the sampled pin vector
    localparam int PIN_SCLK = 0;
    localparam int PIN_CONV_CLK = 1;
    localparam int PIN_SELN = 2;
    localparam int PIN_OEN = 3;
    localparam int PIN_CMD = 4;
    localparam int NUM_PINS = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0c;
    localparam logic [7:0] REG_RESULT = 8'h10;

    // Field positions
    localparam int CTRL_CONV_EN_BIT = 0;
    localparam int EV_DONE_BIT = 0;
    localparam int EV_READ_BIT = 1;
    localparam int EV_ABORT_BIT = 2;
    localparam int NUM_EVENTS = 3;

    // Reset values
    localparam logic [0:0] CTRL_RESET = 1'h1;
    localparam logic [NUM_EVENTS-1:0] MASK_RESET = 3'h0;
    localparam logic [NUM_EVENTS-1:0] STATUS_RESET = 3'h0;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b100
    } seq_state_t;

endpackage : adc_seq_pkg

// file: rtl/adc_serial_exchange_sequencer.sv
// Serial exchange and conversion sequencer of a 10-bit SAR converter with input mux.
// Assumes the analog core presents its finished code on convertedValue, stable at end
// of conversion, and a register master on the same clock.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_exchange_sequencer #(
    parameter int ConvCycles = adc_seq_pkg::CONV_CYCLES,
    parameter int ExchCycles = adc_seq_pkg::EXCH_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic serialClockPin,
    input wire logic conversionClockPin,
    input wire logic selectNPin,
    input wire logic outputEnableNPin,
    input wire logic serialCommandIn,
    output logic serialOut,
    output logic serialOutEn,
    output logic conversionBusyFlag,
    output logic [adc_seq_pkg::CHAN_BITS-1:0] channelSel,
    output logic trackEnable,
    input wire logic [adc_seq_pkg::RESULT_BITS-1:0] convertedValue,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin sampling
    logic [adc_seq_pkg::NUM_PINS-1:0] pinRaw;
    logic [adc_seq_pkg::NUM_PINS-1:0] pinLvl;
    logic [adc_seq_pkg::NUM_PINS-1:0] pinRise;
    logic [adc_seq_pkg::NUM_PINS-1:0] pinFall;

    assign pinRaw = {serialCommandIn, outputEnableNPin, selectNPin, conversionClockPin, serialClockPin};

    // One synchroniser per pin, clocks included
    for (genvar i = 0; i < adc_seq_pkg::NUM_PINS; i++) begin : g_sync
        pin_edge_sync u_sync (
            .clock(clock),
            .nrst(nrst),
            .pinIn(pinRaw[i]),
            .level(pinLvl[i]),
            .rise(pinRise[i]),
            .fall(pinFall[i])
        );
    end

    logic sclkRise;
    logic sclkFall;
    logic convClkRise;
    logic selLow;
    logic selRaise;
    logic oeLow;
    logic cmdBit;

    assign sclkRise = pinRise[adc_seq_pkg::PIN_SCLK];
    assign sclkFall = pinFall[adc_seq_pkg::PIN_SCLK];
    assign convClkRise = pinRise[adc_seq_pkg::PIN_CONV_CLK];
    assign selLow = ~pinLvl[adc_seq_pkg::PIN_SELN];
    assign selRaise = pinRise[adc_seq_pkg::PIN_SELN];
    assign oeLow = ~pinLvl[adc_seq_pkg::PIN_OEN];
    assign cmdBit = pinLvl[adc_seq_pkg::PIN_CMD];

    ////////////////////////////////////////////////////////////////////////////////
    // State and datapath registers
    adc_seq_pkg::seq_state_t state_q;
    logic [3:0] bitCount_q;
    logic [adc_seq_pkg::ADDR_BITS-1:0] addr_q;
    logic fmtRight_q;
    logic [3:0] sampleCount_q;
    logic [5:0] convCount_q;
    logic busy_q;
    logic resultValid_q;
    logic [adc_seq_pkg::RESULT_BITS-1:0] result_q;
    logic [adc_seq_pkg::SHIFT_BITS-1:0] shift_q;
    logic serialOut_q;
    logic serialOutEn_q;
    logic ctrlConvEn_q;
    logic [adc_seq_pkg::NUM_EVENTS-1:0] status_q;
    logic [adc_seq_pkg::NUM_EVENTS-1:0] mask_q;
    logic [31:0] regRdata_q;
    logic irq_q;

    logic startSample;
    logic sampleDone;
    logic convDone;
    logic exchActive;
    logic shiftNow;

    // Exchange progress and sequencer triggers
    assign exchActive = selLow && (state_q != adc_seq_pkg::ST_CONVERT);
    assign startSample = (state_q == adc_seq_pkg::ST_IDLE) && exchActive && sclkRise && ctrlConvEn_q
                         && (bitCount_q == 4'(adc_seq_pkg::ADDR_BITS - 1));
    assign sampleDone = (state_q == adc_seq_pkg::ST_SAMPLE) && (sclkRise || sclkFall)
                        && (sampleCount_q == 4'(adc_seq_pkg::SAMPLE_HALF_PERIODS - 1));
    assign convDone = (state_q == adc_seq_pkg::ST_CONVERT) && convClkRise
                      && (convCount_q == 6'(ConvCycles - 1));
    assign shiftNow = exchActive && oeLow && sclkFall;

    ////////////////////////////////////////////////////////////////////////////////
    // Rising edge count of the current exchange; restarts on select high or busy fall
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bitCount_q <= 4'h0;
        end else if (!selLow || convDone) begin
            bitCount_q <= 4'h0;
        end else if (exchActive && sclkRise && bitCount_q < 4'(ExchCycles)) begin
            bitCount_q <= bitCount_q + 4'h1;
        end
    end

    // Address and format bits shift in on rising edges
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            addr_q <= 4'h0;
        end else if (exchActive && sclkRise && bitCount_q < 4'(adc_seq_pkg::ADDR_BITS)) begin
            addr_q <= {addr_q[2:0], cmdBit};
        end
    end

    // Sequencer: idle holding result, sampling, converting
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= adc_seq_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                adc_seq_pkg::ST_IDLE: begin
                    if (startSample) begin
                        state_q <= adc_seq_pkg::ST_SAMPLE;
                    end
                end
                adc_seq_pkg::ST_SAMPLE: begin
                    if (!selLow) begin
                        state_q <= adc_seq_pkg::ST_IDLE;
                    end else if (sampleDone) begin
                        state_q <= adc_seq_pkg::ST_CONVERT;
                    end
                end
                adc_seq_pkg::ST_CONVERT: begin
                    if (convDone) begin
                        state_q <= adc_seq_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Latched format and sampling window length
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fmtRight_q <= 1'b0;
            sampleCount_q <= 4'h0;
        end else if (startSample) begin
            fmtRight_q <= cmdBit;
            sampleCount_q <= 4'h0;
        end else if (state_q == adc_seq_pkg::ST_SAMPLE && (sclkRise || sclkFall)) begin
            sampleCount_q <= sampleCount_q + 4'h1;
        end
    end

    // Conversion clock count and busy flag
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            convCount_q <= 6'h00;
            busy_q <= 1'b0;
        end else if (sampleDone && selLow) begin
            convCount_q <= 6'h00;
            busy_q <= 1'b1;
        end else if (convDone) begin
            busy_q <= 1'b0;
        end else if (state_q == adc_seq_pkg::ST_CONVERT && convClkRise) begin
            convCount_q <= convCount_q + 6'h01;
        end
    end

    // Result is held until a new exchange starts the next conversion
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            resultValid_q <= 1'b0;
            result_q <= 10'h000;
        end else if (convDone) begin
            resultValid_q <= 1'b1;
            result_q <= convertedValue;
        end else if (startSample) begin
            resultValid_q <= 1'b0;
        end
    end

    // Output shift register: load at busy fall, shift on falling edges
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            shift_q <= 16'h0000;
        end else if (convDone) begin
            shift_q <= fmtRight_q ? {6'h00, convertedValue} : {convertedValue, 6'h00};
        end else if (shiftNow) begin
            shift_q <= {shift_q[14:0], 1'b0};
        end
    end

    // Serial output pin: zero from the edge busy rises, MSB one clock after it is loaded
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            serialOut_q <= 1'b0;
            serialOutEn_q <= 1'b0;
        end else begin
            serialOut_q <= (state_q == adc_seq_pkg::ST_CONVERT || sampleDone) ? 1'b0 : shift_q[15];
            serialOutEn_q <= selLow;
        end
    end
    assign serialOut = serialOut_q;
    assign serialOutEn = serialOutEn_q;
    assign conversionBusyFlag = busy_q;
    assign channelSel = addr_q[3:1];
    assign trackEnable = (state_q == adc_seq_pkg::ST_SAMPLE);

    ////////////////////////////////////////////////////////////////////////////////
    // Register port, status events and interrupt
    logic [adc_seq_pkg::NUM_EVENTS-1:0] events;

    assign events = {(state_q == adc_seq_pkg::ST_CONVERT) && selRaise, startSample && resultValid_q, convDone};

    // Control and mask registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrlConvEn_q <= adc_seq_pkg::CTRL_RESET[0];
            mask_q <= adc_seq_pkg::MASK_RESET;
        end else if (regWrite && regAddr == adc_seq_pkg::REG_CTRL) begin
            ctrlConvEn_q <= regWdata[adc_seq_pkg::CTRL_CONV_EN_BIT];
        end else if (regWrite && regAddr == adc_seq_pkg::REG_MASK) begin
            mask_q <= regWdata[adc_seq_pkg::NUM_EVENTS-1:0];
        end
    end

    // Sticky status, write one to clear, a new event wins over the clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            status_q <= adc_seq_pkg::STATUS_RESET;
        end else begin
            status_q <= (status_q & ~((regWrite && regAddr == adc_seq_pkg::REG_STATUS) ?
                         regWdata[adc_seq_pkg::NUM_EVENTS-1:0] : 3'h0)) | events;
        end
    end

    // Read data one cycle after the strobe, unmapped reads give zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            regRdata_q <= 32'h0000_0000;
        end else if (regRead) begin
            unique case (regAddr)
                adc_seq_pkg::REG_CTRL: regRdata_q <= {31'h0, ctrlConvEn_q};
                adc_seq_pkg::REG_STATUS: regRdata_q <= {29'h0, status_q};
                adc_seq_pkg::REG_MASK: regRdata_q <= {29'h0, mask_q};
                adc_seq_pkg::REG_STATE: regRdata_q <= {22'h0, addr_q, fmtRight_q, state_q, resultValid_q, busy_q};
                adc_seq_pkg::REG_RESULT: regRdata_q <= {22'h0, result_q};
                default: regRdata_q <= 32'h0000_0000;
            endcase
        end else begin
            regRdata_q <= 32'h0000_0000;
        end
    end

    // Level interrupt from unmasked status
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);
        end
    end

    assign regRdata = regRdata_q;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [5:0] busyClocks_q;
    // Counts conversion clocks seen while busy
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            busyClocks_q <= 6'h00;
        end else if (sampleDone && selLow) begin
            busyClocks_q <= 6'h00;
        end else if (busy_q && convClkRise) begin
            busyClocks_q <= busyClocks_q + 6'h01;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_zero_while_busy: assert property (busy_q |-> !serialOut)
        else $error("serial output not zero during conversion");
    a_msb_at_done: assert property (convDone ##1 !shiftNow |-> ##1
        serialOut == (fmtRight_q ? 1'b0 : result_q[9]))
        else $error("result MSB not presented at busy fall");
    a_float_on_select: assert property (!selLow |=> !serialOutEn)
        else $error("serial output driven while select high");
    a_busy_length: assert property ($fell(busy_q) |-> busyClocks_q == 6'(ConvCycles))
        else $error("busy did not last the conversion clock count");
    a_addr_msb_capture: assert property (exchActive && sclkRise && bitCount_q == 4'h0
        |=> addr_q[0] == $past(cmdBit))
        else $error("channel address MSB not captured");
    a_shift_on_fall: assert property (shiftNow && !convDone
        |=> shift_q == {$past(shift_q[14:0]), 1'b0})
        else $error("result bit not shifted on falling edge");
    a_busy_after_sample: assert property ($rose(busy_q) |-> $past(state_q) == adc_seq_pkg::ST_SAMPLE
        && $past(sampleCount_q) == 4'(adc_seq_pkg::SAMPLE_HALF_PERIODS - 1))
        else $error("conversion started before sampling window ended");
    a_sample_start: assert property (startSample |=> trackEnable && !busy_q)
        else $error("sampling did not start on fourth rising edge");
    a_result_held: assert property (resultValid_q && !startSample |=> resultValid_q && $stable(result_q))
        else $error("held result lost without a read");
    a_read_consumes: assert property (startSample |=> !resultValid_q ##[1:300] !selLow || busy_q)
        else $error("reading exchange did not consume result");

    c_conversion_done: cover property (convDone);
    c_select_abort: cover property (state_q == adc_seq_pkg::ST_CONVERT && selRaise);
    c_read_right_fmt: cover property (startSample && resultValid_q && fmtRight_q);
    c_irq_raised: cover property ($rose(irq));
endmodule : adc_serial_exchange_sequencer
`default_nettype wire

// file: rtl/pin_edge_sync.sv
// Two-flop synchroniser with edge detection for one external pin.
// Assumes the pin is asynchronous to clock and changes no faster than a few cycles.
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
    input wire logic clock,
    input wire logic nrst,
    input wire logic pinIn,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // First flop feeds only the second
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= pinIn;
            sync_q <= meta_q;
        end
    end

    // Delayed copy for edge finding
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sync_q;
        end
    end

    // Level and one-cycle edge pulses
    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

endmodule : pin_edge_sync
`default_nettype wire

// file: tb/host_serial_port.sv
// Host serial port model: exchange clock, select, output enable and command bits.
// Assumes the sequencer samples every pin with its own faster clock.
`timescale 1ns/1ps
`default_nettype none
module host_serial_port (
    output logic serialClock,
    output logic conversionClock,
    output logic selectN,
    output logic outputEnableN,
    output logic commandBit,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic busyFlag
);
    localparam int HalfPeriod = 24;
    logic lastLevel = 1'b0;
    wire logic dataLine;

    ////////////////////////////////////////////////////////////////////////////////
    // Floating result line reads as the inverse of its last driven level
    assign dataLine = serialOutEn ? serialOut : ~lastLevel;
    always @(serialOut or serialOutEn) begin
        if (serialOutEn) begin
            lastLevel = serialOut;
        end
    end

    // Select and output enable start low, only set_select moves select; exchange clock parked low between exchanges
    initial begin
        serialClock = 1'b0;
        selectN = 1'b0;
        outputEnableN = 1'b0;
        commandBit = 1'b0;
        conversionClock = 1'b0;
    end

    // Conversion clock runs free, phase unrelated to the exchange clock
    initial begin
        #13;
        forever #HalfPeriod conversionClock = ~conversionClock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One ten-cycle exchange; first eight result bits read before each rising edge
    task automatic exchange(input logic [3:0] cmd, output logic [7:0] got);
        for (int i = 0; i < 10; i++) begin
            commandBit = (i < 4) ? cmd[3 - i] : ~commandBit;
            #HalfPeriod;
            if (i < 8) begin
                got[7 - i] = dataLine;
            end
            serialClock = 1'b1;
            #HalfPeriod;
            serialClock = 1'b0;
        end
    endtask : exchange

    // Moves select, then lets the synchroniser settle
    task automatic set_select(input logic level);
        selectN = level;
        #100;
    endtask : set_select

endmodule : host_serial_port
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the converter exchange sequencer.
// Assumes the host model drives all pins; the bench owns registers and core result.
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", name, exp, got); end end
module tb_top;
    logic clock, nrst, serialClockPin, conversionClockPin, selectNPin, outputEnableNPin;
    logic serialCommandIn, serialOut, serialOutEn, conversionBusyFlag, trackEnable, irq;
    logic regWrite, regRead, zeroBroken;
    logic [adc_seq_pkg::CHAN_BITS-1:0] channelSel;
    logic [adc_seq_pkg::RESULT_BITS-1:0] convertedValue;
    logic [7:0] regAddr, got;
    logic [31:0] regWdata, regRdata, rdData;
    int n_errors = 0;
    int checked = 0;
    int convClkCount = 0;
    int trackCount = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, design and host
    initial clock = 1'b0;
    always #2.5 clock = ~clock;
    adc_serial_exchange_sequencer dut (.clock(clock), .nrst(nrst), .serialClockPin(serialClockPin),
        .conversionClockPin(conversionClockPin), .selectNPin(selectNPin), .outputEnableNPin(outputEnableNPin),
        .serialCommandIn(serialCommandIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .conversionBusyFlag(conversionBusyFlag), .channelSel(channelSel), .trackEnable(trackEnable),
        .convertedValue(convertedValue), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .irq(irq));
    host_serial_port host (.serialClock(serialClockPin), .conversionClock(conversionClockPin),
        .selectN(selectNPin), .outputEnableN(outputEnableNPin), .commandBit(serialCommandIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn), .busyFlag(conversionBusyFlag));

    // Conversion clocks while busy, sampling cycles, and result line during conversion
    always @(posedge conversionBusyFlag) convClkCount = 0;
    always @(posedge conversionClockPin) if (conversionBusyFlag === 1'b1) convClkCount++;
    always @(posedge clock) begin
        if (trackEnable === 1'b1) trackCount++;
        if (conversionBusyFlag === 1'b1 && serialOutEn === 1'b1 && serialOut !== 1'b0) zeroBroken = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register port and sequencing tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : rd

    task automatic xfer(input logic [3:0] cmd);
        trackCount = 0;
        zeroBroken = 1'b0;
        host.exchange(cmd, got);
    endtask : xfer

    // Waits out a conversion, then checks its timing and the first result bit
    task automatic wait_done(input logic expMsb);
        int n;
        n = 0;
        while (conversionBusyFlag === 1'b1 && n < 4000) begin
            @(posedge clock);
            n++;
        end
        `CHK("busy timeout", 1'b1, n < 4000)
        `CHK("conversion clocks", 1'b1, convClkCount >= 40 && convClkCount <= 42)
        `CHK("sampling cycles", 1'b1, trackCount >= 42 && trackCount <= 45)
        `CHK("zero while converting", 1'b0, zeroBroken)
        repeat (3) @(posedge clock);
        #1 if (selectNPin === 1'b0) `CHK("msb at busy fall", expMsb, serialOut)
    endtask : wait_done

    task automatic complete_run();
        if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    initial begin
        #200000;
        n_errors++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        nrst = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
        zeroBroken = 1'b0;
        convertedValue = 10'h2b5;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        rd(adc_seq_pkg::REG_CTRL, rdData);
        `CHK("ctrl reset", 32'h1, rdData)
        rd(adc_seq_pkg::REG_STATUS, rdData);
        `CHK("status reset", 32'h0, rdData)
        rd(8'h20, rdData);
        `CHK("unmapped", 32'h0, rdData)
        wr(adc_seq_pkg::REG_STATE, 32'hffffffff);
        rd(adc_seq_pkg::REG_STATE, rdData);
        `CHK("state read only", 32'h4, rdData)
        wr(adc_seq_pkg::REG_MASK, 32'h1);
        // First conversion: channel 5, left justified
        xfer(4'b1010);
        `CHK("channel", 3'h5, channelSel)
        wait_done(1'b1);
        `CHK("irq raised", 1'b1, irq)
        wr(adc_seq_pkg::REG_MASK, 32'h0);
        rd(adc_seq_pkg::REG_STATUS, rdData);
        `CHK("irq masked", 1'b0, irq)
        `CHK("done event", 1'b1, rdData[adc_seq_pkg::EV_DONE_BIT])
        wr(adc_seq_pkg::REG_STATUS, 32'h1);
        wr(adc_seq_pkg::REG_MASK, 32'h1);
        rd(adc_seq_pkg::REG_STATUS, rdData);
        `CHK("irq cleared", 1'b0, irq)
        // Result held through a long pause, read by the exchange that restarts
        repeat (2000) @(posedge clock);
        convertedValue <= 10'h1c3;
        xfer(4'b0111);
        `CHK("left data", 8'had, got)
        `CHK("channel", 3'h3, channelSel)
        rd(adc_seq_pkg::REG_STATUS, rdData);
        `CHK("consumed", 1'b1, rdData[adc_seq_pkg::EV_READ_BIT])
        `CHK("restarted", 1'b1, conversionBusyFlag)
        wait_done(1'b0);
        // Right justified read, then select raised mid conversion
        @(posedge clock);
        convertedValue <= 10'h3ff;
        xfer(4'b1000);
        `CHK("right data", 8'h01, got)
        host.set_select(1'b1);
        `CHK("floating", 1'b0, serialOutEn)
        wait_done(1'b1);
        rd(adc_seq_pkg::REG_STATUS, rdData);
        `CHK("abort event", 1'b1, rdData[adc_seq_pkg::EV_ABORT_BIT])
        host.set_select(1'b0);
        `CHK("msb after float", 1'b1, serialOut)
        xfer(4'b0000);
        `CHK("intact data", 8'hff, got)
        wait_done(1'b1);
        // Conversions disabled: exchange does not start one
        wr(adc_seq_pkg::REG_CTRL, 32'h0);
        host.set_select(1'b1);
        host.set_select(1'b0);
        xfer(4'b0010);
        repeat (100) @(posedge clock);
        `CHK("no conversion", 1'b0, conversionBusyFlag)
        `CHK("no sampling", 0, trackCount)
        complete_run();
    end

endmodule : tb_top
`default_nettype wire
